// ### verilog/pxp_params.svh
// register offsets, field positions and reset values of the paged register bank
`ifndef PXP_PARAMS_SVH
`define PXP_PARAMS_SVH

// ----------------------------------------
// page selection
// ----------------------------------------
`define PXP_ADDR_PAGE_SEL     5'h1F
`define PXP_PAGED_LO          5'h10
`define PXP_PAGE_MAIN         16'h0000
`define PXP_PAGE_EXT1         16'h0001

// ----------------------------------------
// page 1 register offsets
// ----------------------------------------
`define PXP_ADDR_FIBER_CTRL   5'h10
`define PXP_ADDR_GOOD_CRC     5'h12
`define PXP_ADDR_EXT_MODE     5'h13

// ----------------------------------------
// fiber media control fields
// ----------------------------------------
`define PXP_FMC_TX_RF_HI      15
`define PXP_FMC_TX_RF_LO      14
`define PXP_FMC_LP_RF_HI      13
`define PXP_FMC_LP_RF_LO      12
`define PXP_FMC_ALLOW_1000X   9
`define PXP_FMC_ALLOW_100FX   8
`define PXP_FMC_FEF           6
`define PXP_FMC_TX_RF_RST     2'h0
`define PXP_FMC_ALLOW_RST     1'h1

// ----------------------------------------
// good-crc counter fields
// ----------------------------------------
`define PXP_CRC_SEEN_BIT      15
`define PXP_CRC_COUNT_W       14
`define PXP_CRC_MODULUS_M1    14'h270F

// ----------------------------------------
// extended mode control fields
// ----------------------------------------
`define PXP_EMC_LED_EXT_HI    15
`define PXP_EMC_LED_EXT_LO    12
`define PXP_EMC_BLINK_SUPP    11
`define PXP_EMC_FAST_FAIL     4
`define PXP_EMC_XOVER_HI      3
`define PXP_EMC_XOVER_LO      2
`define PXP_EMC_SIGNAL_DETECT_INPUT_POL    0
`define PXP_EMC_RST           16'h0000

`endif

// ### verilog/pxp_pkg.sv
// types shared by the paged register bank
package pxp_pkg;

	typedef enum logic [1:0] {
		PXP_XOVER_AUTO,
		PXP_XOVER_RSVD,
		PXP_XOVER_MDI,
		PXP_XOVER_MDIX
	} pxp_xover_t;

	typedef enum logic {
		PXP_BUS_IDLE,
		PXP_BUS_ACK
	} pxp_bus_st_t;

endpackage

// ### verilog/pxp_regs.sv
// per-port bank of paged management registers with avalon-mm slave
`timescale 1ns/1ps
`include "pxp_params.svh"

// Summary of operation
// - with page 1 selected, addresses 16 to 30 reach page 1 registers.
// - writing 0x0000 to address 31 returns 16 to 30 to main space.
// - addresses 0 to 15 reach the same registers on every page.
// - fiber media control acts only on ports 0 to 3.
// - transmit remote fault bits 15:14 are read/write, reset 00, sent to partner.
// - bits 13:12 show partner's advertised remote fault, read only.
// - bit 9 permits 1000BASE-X fiber link-up, reset 1.
// - bit 8 permits 100BASE-FX fiber link-up, reset 1.
// - bit 6 sets on 100BASE-FX far end fault, clears on read.
// - counter bit 15 flags any good packet since last read, clears on read.
// - bits 13:0 count good-crc packets modulo 10000, wrap, reset zero.
// - the good-crc count clears when read.
// - bits 15:12 select extended led behaviour per led, reset 0.
// - bit 11 set suppresses led blink after low-power hold release.
// - bit 4 enables fast link failure pin on port 0 only (stays 0 on other ports), otherwise the pin is gpio.
// - bits 3:2 choose auto, forced mdi or forced mdi-x crossover.
// - bit 0 set makes signal detect inputs active low.
module pxp_regs
	import pxp_pkg::*;
#(
	parameter int PORT_ID = 0,
	parameter int N_LED   = 4,
	parameter int N_SIGNAL_DETECT_INPUT = 4
) (
	// clock and reset
	input  wire logic                    clk,
	input  wire logic                    rst_n,
	// avalon-mm slave
	input  wire logic [4:0]              avs_address,
	input  wire logic                    avs_read,
	input  wire logic                    avs_write,
	input  wire logic [15:0]             avs_writedata,
	output logic      [15:0]             avs_readdata,
	output logic                         avs_waitrequest,
	// main space registers 0..30, outside this bank
	output logic      [4:0]              main_address,
	output logic                         main_read,
	output logic                         main_write,
	output logic      [15:0]             main_writedata,
	input  wire logic [15:0]             main_readdata,
	// events from the media logic (same clock)
	input  wire logic [1:0]              link_partner_rf,
	input  wire logic                    fef_event,
	input  wire logic                    good_crc_pkt,
	// async pins
	input  wire logic [N_SIGNAL_DETECT_INPUT-1:0]     signal_detect_input,
	// controls toward the port
	output logic      [1:0]              tx_remote_fault,
	output logic                         allow_1000x_linkup,
	output logic                         allow_100fx_linkup,
	output logic      [N_LED-1:0]        led_ext_mode,
	output logic                         led_blink_suppress,
	output logic                         fast_fail_enable,
	output pxp_xover_t                   xover_mode,
	output logic      [N_SIGNAL_DETECT_INPUT-1:0]     signal_detect_active
);

	// the field layout only serves four leds and four signal-detect pins
	if (N_LED != 4 || N_SIGNAL_DETECT_INPUT != 4 || PORT_ID < 0) begin : g_bad_params
		$error("pxp_regs: unsupported parameter value");
	end

	localparam logic FIBER_PORT = (PORT_ID <= 3);

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [15:0]                 page_r;
	logic [1:0]                  tx_rf_r;
	logic                        allow_1000x_r;
	logic                        allow_100fx_r;
	logic                        fef_r;
	logic                        seen_r;
	logic [`PXP_CRC_COUNT_W-1:0] count_r;
	logic [15:0]                 emc_r;
	pxp_bus_st_t                 bus_st_r;
	logic                        main_pend_r;
	logic [N_SIGNAL_DETECT_INPUT-1:0]         sd_meta_r;
	logic [N_SIGNAL_DETECT_INPUT-1:0]         sd_sync_r;

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	logic req;
	logic ext_sel;
	logic page_hit;
	logic fmc_hit;
	logic crc_hit;
	logic emc_hit;
	logic rd_take;
	logic wr_take;

	// a forwarded access is still pending while main_pend_r is up; taking it again would strobe twice
	assign req      = (avs_read | avs_write) && bus_st_r == PXP_BUS_IDLE && !main_pend_r;
	// page selector itself and 0..15 never depend on page
	assign page_hit = avs_address == `PXP_ADDR_PAGE_SEL;
	assign ext_sel  = page_r == `PXP_PAGE_EXT1 && avs_address >= `PXP_PAGED_LO && !page_hit;
	assign fmc_hit  = ext_sel && avs_address == `PXP_ADDR_FIBER_CTRL;
	assign crc_hit  = ext_sel && avs_address == `PXP_ADDR_GOOD_CRC;
	assign emc_hit  = ext_sel && avs_address == `PXP_ADDR_EXT_MODE;
	assign rd_take  = req && avs_read;
	assign wr_take  = req && avs_write;

	// ----------------------------------------
	// bus handshake: one wait cycle for page 1 and page selector, two for forwarded main-space accesses
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n)
			bus_st_r <= PXP_BUS_IDLE;
		else if (req && (ext_sel || page_hit))
			bus_st_r <= PXP_BUS_ACK;
		else if (main_pend_r)
			bus_st_r <= PXP_BUS_ACK;
		else
			bus_st_r <= PXP_BUS_IDLE;
	end

	// main-space accesses are forwarded as one-cycle strobes
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			main_pend_r    <= 1'b0;
			main_read      <= 1'b0;
			main_write     <= 1'b0;
			main_address   <= 5'h00;
			main_writedata <= 16'h0000;
		end else begin
			main_pend_r    <= req && !ext_sel && !page_hit;
			main_read      <= rd_take && !ext_sel && !page_hit;
			main_write     <= wr_take && !ext_sel && !page_hit;
			main_address   <= avs_address;
			main_writedata <= avs_writedata;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			avs_waitrequest <= 1'b1;
		else
			avs_waitrequest <= !((req && (ext_sel || page_hit)) || main_pend_r);
	end

	// ----------------------------------------
	// read data; reserved bits stay zero
	// ----------------------------------------
	logic [15:0] rd_nxt;

	always_comb begin
		rd_nxt = 16'h0000;
		if (page_hit)
			rd_nxt = page_r;
		else if (fmc_hit && FIBER_PORT) begin
			rd_nxt[`PXP_FMC_TX_RF_HI:`PXP_FMC_TX_RF_LO] = tx_rf_r;
			rd_nxt[`PXP_FMC_LP_RF_HI:`PXP_FMC_LP_RF_LO] = link_partner_rf;
			rd_nxt[`PXP_FMC_ALLOW_1000X]                = allow_1000x_r;
			rd_nxt[`PXP_FMC_ALLOW_100FX]                = allow_100fx_r;
			rd_nxt[`PXP_FMC_FEF]                        = fef_r;
		end else if (crc_hit) begin
			rd_nxt[`PXP_CRC_SEEN_BIT]          = seen_r;
			rd_nxt[`PXP_CRC_COUNT_W-1:0]       = count_r;
		end else if (emc_hit)
			rd_nxt = emc_r;
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			avs_readdata <= 16'h0000;
		else if (rd_take && (ext_sel || page_hit))
			avs_readdata <= rd_nxt;
		else if (main_pend_r)
			avs_readdata <= main_readdata;
	end

	// ----------------------------------------
	// page selector
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n)
			page_r <= `PXP_PAGE_MAIN;
		else if (wr_take && page_hit)
			page_r <= avs_writedata;
	end

	// ----------------------------------------
	// fiber media control
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tx_rf_r       <= `PXP_FMC_TX_RF_RST;
			allow_1000x_r <= `PXP_FMC_ALLOW_RST;
			allow_100fx_r <= `PXP_FMC_ALLOW_RST;
		end else if (wr_take && fmc_hit && FIBER_PORT) begin
			tx_rf_r       <= avs_writedata[`PXP_FMC_TX_RF_HI:`PXP_FMC_TX_RF_LO];
			allow_1000x_r <= avs_writedata[`PXP_FMC_ALLOW_1000X];
			allow_100fx_r <= avs_writedata[`PXP_FMC_ALLOW_100FX];
		end
	end

	// far end fault: a new event in the read cycle wins over the clear
	always_ff @(posedge clk) begin
		if (!rst_n)
			fef_r <= 1'b0;
		else if (fef_event && FIBER_PORT)
			fef_r <= 1'b1;
		else if (rd_take && fmc_hit)
			fef_r <= 1'b0;
	end

	// ----------------------------------------
	// good-crc counter; a packet in the read cycle is kept as count 1
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			seen_r  <= 1'b0;
			count_r <= '0;
		end else if (rd_take && crc_hit) begin
			seen_r  <= good_crc_pkt;
			count_r <= {{(`PXP_CRC_COUNT_W-1){1'b0}}, good_crc_pkt};
		end else if (good_crc_pkt) begin
			seen_r  <= 1'b1;
			count_r <= (count_r == `PXP_CRC_MODULUS_M1) ? '0 : count_r + 1'b1;
		end
	end

	// ----------------------------------------
	// extended mode control
	// ----------------------------------------
	localparam logic [15:0] EMC_MASK = 16'hF81D;

	always_ff @(posedge clk) begin
		if (!rst_n)
			emc_r <= `PXP_EMC_RST;
		else if (wr_take && emc_hit) begin
			emc_r <= avs_writedata & EMC_MASK;
			// fast fail only from the first port instance
			if (PORT_ID != 0)
				emc_r[`PXP_EMC_FAST_FAIL] <= emc_r[`PXP_EMC_FAST_FAIL];
		end
	end

	// ----------------------------------------
	// signal detect: two-flop sync then polarity
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sd_meta_r <= '0;
			sd_sync_r <= '0;
		end else begin
			sd_meta_r <= signal_detect_input;
			sd_sync_r <= sd_meta_r;
		end
	end

	// ----------------------------------------
	// registered control outputs
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tx_remote_fault      <= `PXP_FMC_TX_RF_RST;
			allow_1000x_linkup   <= 1'b0;
			allow_100fx_linkup   <= 1'b0;
			led_ext_mode         <= '0;
			led_blink_suppress   <= 1'b0;
			fast_fail_enable     <= 1'b0;
			xover_mode           <= PXP_XOVER_AUTO;
			signal_detect_active <= '0;
		end else begin
			tx_remote_fault      <= FIBER_PORT ? tx_rf_r : 2'h0;
			allow_1000x_linkup   <= FIBER_PORT && allow_1000x_r;
			allow_100fx_linkup   <= FIBER_PORT && allow_100fx_r;
			led_ext_mode         <= emc_r[`PXP_EMC_LED_EXT_HI:`PXP_EMC_LED_EXT_LO];
			led_blink_suppress   <= emc_r[`PXP_EMC_BLINK_SUPP];
			fast_fail_enable     <= emc_r[`PXP_EMC_FAST_FAIL];
			xover_mode           <= pxp_xover_t'(emc_r[`PXP_EMC_XOVER_HI:`PXP_EMC_XOVER_LO]);
			signal_detect_active <= emc_r[`PXP_EMC_SIGNAL_DETECT_INPUT_POL] ? ~sd_sync_r : sd_sync_r;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	sequence s_cnt_read;
		rd_take && crc_hit && !good_crc_pkt;
	endsequence

	sequence s_main_taken;
		req && !ext_sel && !page_hit;
	endsequence

	sequence s_main_answer;
		main_pend_r ##1 (!avs_waitrequest && !main_read && !main_write);
	endsequence

	property p_main_walk;
		@(posedge clk) disable iff (!rst_n)
		s_main_taken |=> s_main_answer;
	endproperty
	a_main_walk: assert property (p_main_walk) else $error("main access answer out of step");

	property p_wait_once;
		@(posedge clk) disable iff (!rst_n)
		!avs_waitrequest |=> avs_waitrequest;
	endproperty
	a_wait_once: assert property (p_wait_once) else $error("waitrequest low for more than one cycle");

	property p_page_write;
		@(posedge clk) disable iff (!rst_n)
		(wr_take && page_hit) |=> page_r == $past(avs_writedata);
	endproperty
	a_page_write: assert property (p_page_write) else $error("page selector not written");

	property p_page_main;
		@(posedge clk) disable iff (!rst_n)
		(req && page_r != 16'h0001 && avs_address >= 5'h10 && !page_hit)
			|=> main_pend_r;
	endproperty
	a_page_main: assert property (p_page_main) else $error("page 0 still maps page 1");

	property p_low_fixed;
		@(posedge clk) disable iff (!rst_n)
		(req && avs_address < 5'h10) |-> ##1 main_pend_r;
	endproperty
	a_low_fixed: assert property (p_low_fixed) else $error("low address not forwarded");

	property p_ext_route;
		@(posedge clk) disable iff (!rst_n)
		(req && page_r == 16'h0001 && avs_address == 5'h13) |-> ##1 (!main_pend_r && !avs_waitrequest);
	endproperty
	a_ext_route: assert property (p_ext_route) else $error("page 1 access escaped");

	property p_cnt_clear;
		@(posedge clk) disable iff (!rst_n)
		s_cnt_read |=> (count_r == 14'h0000 && !seen_r);
	endproperty
	a_cnt_clear: assert property (p_cnt_clear) else $error("count not cleared by read");

	property p_cnt_wrap;
		@(posedge clk) disable iff (!rst_n)
		(good_crc_pkt && !(rd_take && crc_hit) && count_r == 14'h270F) |=> count_r == 14'h0000;
	endproperty
	a_cnt_wrap: assert property (p_cnt_wrap) else $error("counter did not wrap at 9999");

	property p_cnt_seen;
		@(posedge clk) disable iff (!rst_n)
		good_crc_pkt |=> seen_r;
	endproperty
	a_cnt_seen: assert property (p_cnt_seen) else $error("packet flag missing");

	property p_fef_set;
		@(posedge clk) disable iff (!rst_n)
		(fef_event && FIBER_PORT) |=> fef_r ##1 (fef_r || $past(rd_take && fmc_hit));
	endproperty
	a_fef_set: assert property (p_fef_set) else $error("far end fault lost");

	property p_rsvd_zero;
		@(posedge clk) disable iff (!rst_n)
		(emc_r & ~EMC_MASK) == 16'h0000 ##0 (rd_nxt[1] == 1'b0 || !emc_hit);
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit visible");

	property p_xover_out;
		@(posedge clk) disable iff (!rst_n)
		(wr_take && emc_hit) |-> ##2 xover_mode == pxp_xover_t'($past(avs_writedata[3:2], 2));
	endproperty
	a_xover_out: assert property (p_xover_out) else $error("crossover output wrong");

	property p_allow_out;
		@(posedge clk) disable iff (!rst_n)
		allow_1000x_linkup |-> FIBER_PORT;
	endproperty
	a_allow_out: assert property (p_allow_out) else $error("link-up allowed on non fiber port");

endmodule

// ### sim/tb_pxp_regs.sv
// self-checking bench for the paged register bank
`timescale 1ns/1ps
`include "pxp_params.svh"

`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin failures++; \
	$display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end

module tb_pxp_regs;
	import pxp_pkg::*;

	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic        clk;
	logic        rst_n;
	logic [4:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [15:0] avs_writedata;
	logic [15:0] avs_readdata;
	logic        avs_waitrequest;
	logic [4:0]  main_address;
	logic        main_read;
	logic        main_write;
	logic [15:0] main_writedata;
	logic [15:0] main_readdata;
	logic [1:0]  link_partner_rf;
	logic        fef_event;
	logic        good_crc_pkt;
	logic [3:0]  signal_detect_input;
	logic [1:0]  tx_remote_fault;
	logic        allow_1000x_linkup;
	logic        allow_100fx_linkup;
	logic [3:0]  led_ext_mode;
	logic        led_blink_suppress;
	logic        fast_fail_enable;
	pxp_xover_t  xover_mode;
	logic [3:0]  signal_detect_active;
	logic [15:0] rdata_far;
	logic [1:0]  tx_rf_far;
	logic        allow_x_far;
	logic        allow_fx_far;
	logic        ff_far;
	logic [15:0] d;
	logic [15:0] w;
	int          failures;
	int          cmp_count;
	int          main_rd_cnt = 0;
	int          main_wr_cnt = 0;

	// every forwarded access must strobe the main space exactly once
	always @(posedge clk) begin
		if (main_read === 1'b1)
			main_rd_cnt++;
		if (main_write === 1'b1)
			main_wr_cnt++;
	end

	// main space answers with its own address so routing shows in the data
	assign main_readdata = {8'hA5, 3'h0, main_address};

	pxp_regs #(.PORT_ID(0)) i_dut (
		.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.main_address(main_address), .main_read(main_read), .main_write(main_write),
		.main_writedata(main_writedata), .main_readdata(main_readdata), .link_partner_rf(link_partner_rf),
		.fef_event(fef_event), .good_crc_pkt(good_crc_pkt), .signal_detect_input(signal_detect_input),
		.tx_remote_fault(tx_remote_fault), .allow_1000x_linkup(allow_1000x_linkup),
		.allow_100fx_linkup(allow_100fx_linkup), .led_ext_mode(led_ext_mode),
		.led_blink_suppress(led_blink_suppress), .fast_fail_enable(fast_fail_enable),
		.xover_mode(xover_mode), .signal_detect_active(signal_detect_active));

	// a port outside 0..3 shares the bus; only page-1 answers are compared
	pxp_regs #(.PORT_ID(4)) i_dut_far (
		.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(rdata_far), .avs_waitrequest(),
		.main_address(), .main_read(), .main_write(), .main_writedata(), .main_readdata(16'h0000),
		.link_partner_rf(link_partner_rf), .fef_event(fef_event), .good_crc_pkt(good_crc_pkt),
		.signal_detect_input(signal_detect_input), .tx_remote_fault(tx_rf_far),
		.allow_1000x_linkup(allow_x_far), .allow_100fx_linkup(allow_fx_far), .led_ext_mode(),
		.led_blink_suppress(), .fast_fail_enable(ff_far), .xover_mode(), .signal_detect_active());

	always #50 clk = ~clk;

	// ----------------------------------------
	// bus and event tasks
	// ----------------------------------------
	// waits as long as the slave needs; only the watchdog ends a hang
	task automatic xfer(input logic wr, input logic [4:0] a, input logic [15:0] wd, output logic [15:0] rd);
		@(posedge clk);
		avs_address   <= a;
		avs_writedata <= wd;
		avs_read      <= ~wr;
		avs_write     <= wr;
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic wr(input logic [4:0] a, input logic [15:0] wd);
		logic [15:0] x;
		xfer(1'b1, a, wd, x);
	endtask

	task automatic crc_pulses(input int n);
		repeat (n) begin
			@(posedge clk);
			good_crc_pkt <= 1'b1;
		end
		@(posedge clk);
		good_crc_pkt <= 1'b0;
	endtask

	task automatic done(input string name);
		$display("test %s done", name);
	endtask

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ----------------------------------------
	// watchdog: the tests need about 10100 cycles
	// ----------------------------------------
	initial begin
		#5_000_000;
		failures++;
		end_of_test;
	end

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		clk = 1'b0; rst_n = 1'b0; avs_address = 5'h00; avs_read = 1'b0; avs_write = 1'b0;
		avs_writedata = 16'h0000; link_partner_rf = 2'h0; fef_event = 1'b0; good_crc_pkt = 1'b0;
		signal_detect_input = 4'h5; failures = 0; cmp_count = 0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;

		// reset values on page 1
		wr(`PXP_ADDR_PAGE_SEL, `PXP_PAGE_EXT1);
		xfer(1'b0, `PXP_ADDR_FIBER_CTRL, 16'h0000, d); `CHK(d, 16'h0300)
		xfer(1'b0, `PXP_ADDR_GOOD_CRC, 16'h0000, d);   `CHK(d, 16'h0000)
		xfer(1'b0, `PXP_ADDR_EXT_MODE, 16'h0000, d);   `CHK(d, `PXP_EMC_RST)
		`CHK({allow_1000x_linkup, allow_100fx_linkup, tx_remote_fault}, 4'hC)
		`CHK({led_ext_mode, led_blink_suppress, fast_fail_enable, xover_mode}, 8'h00)
		`CHK(signal_detect_active, 4'h5)
		done("reset");

		// page routing
		xfer(1'b0, 5'h03, 16'h0000, d); `CHK(d, 16'hA503)
		xfer(1'b0, 5'h11, 16'h0000, d); `CHK(d, 16'h0000)
		wr(`PXP_ADDR_PAGE_SEL, `PXP_PAGE_MAIN);
		xfer(1'b0, 5'h10, 16'h0000, d); `CHK(d, 16'hA510)
		xfer(1'b0, 5'h03, 16'h0000, d); `CHK(d, 16'hA503)
		wr(5'h10, 16'h1234);            `CHK(main_writedata, 16'h1234)
		`CHK(main_wr_cnt, 1)
		`CHK(main_rd_cnt, 3)
		wr(`PXP_ADDR_PAGE_SEL, `PXP_PAGE_EXT1);
		done("paging");

		// fiber control, remote fault, far end fault, far port
		link_partner_rf <= 2'h2;
		wr(`PXP_ADDR_FIBER_CTRL, 16'hFFFF);
		xfer(1'b0, `PXP_ADDR_FIBER_CTRL, 16'h0000, d); `CHK(d, 16'hE300)
		`CHK(rdata_far, 16'h0000)
		repeat (3) @(posedge clk);
		`CHK({tx_remote_fault, allow_1000x_linkup, allow_100fx_linkup}, 4'hF)
		`CHK({tx_rf_far, allow_x_far, allow_fx_far}, 4'h0)
		wr(`PXP_ADDR_FIBER_CTRL, 16'h0000);
		repeat (3) @(posedge clk);
		`CHK({allow_1000x_linkup, allow_100fx_linkup}, 2'h0)
		@(posedge clk); fef_event <= 1'b1;
		@(posedge clk); fef_event <= 1'b0;
		xfer(1'b0, `PXP_ADDR_FIBER_CTRL, 16'h0000, d); `CHK(d, 16'h2040)
		xfer(1'b0, `PXP_ADDR_FIBER_CTRL, 16'h0000, d); `CHK(d, 16'h2000)
		done("fiber");

		// good-crc counter, clear on read and wrap past 9999
		crc_pulses(3);
		xfer(1'b0, `PXP_ADDR_GOOD_CRC, 16'h0000, d); `CHK(d, 16'h8003)
		xfer(1'b0, `PXP_ADDR_GOOD_CRC, 16'h0000, d); `CHK(d, 16'h0000)
		crc_pulses(10001);
		xfer(1'b0, `PXP_ADDR_GOOD_CRC, 16'h0000, d); `CHK(d, 16'h8001)
		done("crc");

		// extended mode: every crossover code, both polarities, reserved bits set
		for (int xo = 0; xo < 4; xo++) begin
			w = 16'hA000 | 16'h0800 | 16'h07E0 | 16'h0010 | 16'h0002 | 16'(xo << 2) | 16'(xo & 1);
			wr(`PXP_ADDR_EXT_MODE, w);
			xfer(1'b0, `PXP_ADDR_EXT_MODE, 16'h0000, d); `CHK(d, w & 16'hF81D)
			repeat (5) @(posedge clk);
			`CHK(xover_mode, 2'(xo))
			`CHK({led_ext_mode, led_blink_suppress, fast_fail_enable}, 6'h2B)
			`CHK(ff_far, 1'b0)
			`CHK(signal_detect_active, (xo & 1) ? 4'hA : 4'h5)
		end
		done("ext_mode");
		end_of_test;
	end
endmodule
